// ===== core/link_capture_map.vh
// Register map, field positions, reset values and timing for the receive link capture.
// Included by the capture core and its destuffer; definitions only.
`ifndef LINK_CAPTURE_MAP_VH
`define LINK_CAPTURE_MAP_VH

// Printed offsets are not all multiples of four: these are word indices
`define REG_IDX_LINK_BYTE 8'h28
`define REG_IDX_MATCH_ONE 8'h29
`define REG_IDX_MATCH_TWO 8'h2a
`define REG_IDX_STATUS 8'h2b
`define REG_IDX_MASK 8'h2c
`define REG_IDX_CONTROL 8'h2d

// Field positions
`define FLD_MATCH 2
`define FLD_FULL 4
`define FLD_DESTUFF_EN 0
`define FLD_TX_SRC_HDLC 1

// Reset values
`define RST_BYTE 8'h00
`define RST_MATCH 8'h00
`define RST_MASK 8'h00
`define RST_CONTROL 8'h00

// Timing: one link bit per 250 us, one byte per 2 ms
`define BIT_PERIOD_NS 250000
`define BYTE_PERIOD_NS 2000000
`define CLK_PERIOD_NS 40
`define BIT_PERIOD_CYC (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define BITS_PER_BYTE 4'h8
`define STUFF_RUN 3'h5

`endif

// ===== core/link_zero_destuffer.v
// Zero destuffer for the serial receive link bit stream.
// Assumes bit_valid_i is a one-cycle strobe from the receive framer.
`timescale 1ns/1ns
`default_nettype none
`include "link_capture_map.vh"

module link_zero_destuffer (
    // Clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // Control
    input wire enable_i,
    // Incoming bits
    input wire bit_valid_i,
    input wire bit_data_i,
    // Kept bits
    output wire keep_valid_o,
    output wire keep_data_o
);

    reg [2:0] ones_r;
    reg [2:0] ones_nxt;
    reg drop;

    // A zero after exactly five ones is stuffing; six or more means flag or abort
    always @*
    begin
        drop = enable_i && !bit_data_i && (ones_r == `STUFF_RUN);
        ones_nxt = ones_r;
        if (bit_data_i)
        begin
            if (ones_r != 3'h6)
                ones_nxt = ones_r + 3'h1; // Saturates at six, run length beyond matters not
        end
        else
            ones_nxt = 3'h0;
    end

    // Run counter advances only on real link bits
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            ones_r <= 3'h0;
        else if (bit_valid_i)
            ones_r <= ones_nxt;
    end

    assign keep_valid_o = bit_valid_i && !drop;
    assign keep_data_o = bit_data_i;

endmodule
`default_nettype wire

// ===== core/link_capture.v
// Legacy receive link capture with Avalon-MM register slave and interrupt.
// Assumes link bits arrive as one-cycle strobes synchronous to clk_sys_i,
// one per bit period, from the receive framer (link bits or framing bits).
// The bit period is the framer's business; nothing here measures or enforces it.
//
// Notes on behaviour
// - Each received link or framing bit that the destuffer keeps is shifted singly into the byte assembler.
// - The first bit received becomes bit 0 of the assembled byte.
// - At one bit per 250 us a full byte completes every 2 ms.
// - A completed byte sets the sticky buffer-full status flag.
// - With its mask bit set, buffer-full drives the low-active interrupt pin.
// - A completed byte equal to either match register sets the match flag.
// - With its mask bit set, the match flag drives the low-active interrupt pin.
// - With destuffing enabled, a zero following five ones is discarded.
// - A zero following six or more ones is kept.
// - The capture runs beside the newer receive controllers, independent of them.
// - Outgoing link data comes from one source only, legacy or HDLC.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "link_capture_map.vh"

module link_capture (
    // Clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // Avalon-MM slave
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Receive link bits from framer
    input wire rx_bit_valid_i,
    input wire rx_bit_data_i,
    // Transmit link source selection
    input wire tx_legacy_bit_i,
    input wire tx_hdlc_bit_i,
    output reg tx_link_bit_o,
    // Byte strobe for observers
    output reg byte_done_o,
    // Interrupt
    output wire irq_n_o
);

    // Register layout, one byte per word index, data bits 31:8 read as zero:
    //   link byte   read only, replaced whole when the eighth kept bit lands
    //   match one   first compare byte for the match flag
    //   match two   second compare byte for the match flag
    //   status      bit 4 buffer full, bit 2 match; write a one to clear a flag
    //   mask        same layout as status; a set bit lets that flag pull irq_n_o low
    //   control     bit 0 zero destuffer enable, bit 1 transmit source select
    // An unread byte is simply replaced by the next one: software has one
    // byte time to fetch it, and nothing here flags an overrun.

    // Link side: assembler and the readable byte
    reg [7:0] shift_r;
    reg [3:0] count_r;
    reg [7:0] link_byte_r;

    // Software registers and the next status value
    reg [7:0] match_one_r;
    reg [7:0] match_two_r;
    reg [7:0] status_r;
    reg [7:0] status_nxt;
    reg [7:0] mask_r;
    reg [7:0] control_r;

    // Bus answer sequencer; its state is also the answering-cycle flag
    localparam ACK_IDLE = 1'b0;
    localparam ACK_ANSWER = 1'b1;
    reg ack_r;
    reg ack_nxt;

    // Bit positions of the one-hot register select
    localparam SEL_BYTE = 0;
    localparam SEL_MATCH_ONE = 1;
    localparam SEL_MATCH_TWO = 2;
    localparam SEL_STATUS = 3;
    localparam SEL_MASK = 4;
    localparam SEL_CONTROL = 5;

    // Destuffer output and byte events
    wire keep_valid;
    wire keep_data;
    wire [7:0] assembled;
    wire byte_ev;
    wire match_ev;

    // Decoded bus strobes
    wire [5:0] reg_sel;
    wire wr_lane0;
    wire [7:0] wr_byte;
    wire clr_full;
    wire clr_match;

    // Compare one byte to a match register
    function is_match;
        input [7:0] a;
        input [7:0] b;
        begin
            is_match = (a == b);
        end
    endfunction

    // One-hot register select; an unmapped index selects nothing
    function [5:0] decode_index;
        input [7:0] addr;
        begin
            if (addr == `REG_IDX_LINK_BYTE)
                decode_index = 6'h01;
            else if (addr == `REG_IDX_MATCH_ONE)
                decode_index = 6'h02;
            else if (addr == `REG_IDX_MATCH_TWO)
                decode_index = 6'h04;
            else if (addr == `REG_IDX_STATUS)
                decode_index = 6'h08;
            else if (addr == `REG_IDX_MASK)
                decode_index = 6'h10;
            else if (addr == `REG_IDX_CONTROL)
                decode_index = 6'h20;
            else
                decode_index = 6'h00;
        end
    endfunction

    // Sticky flag step; the event wins so a clear never swallows a new one
    function sticky_next;
        input cur;
        input ev;
        input clr;
        begin
            if (ev)
                sticky_next = 1'b1;
            else if (clr)
                sticky_next = 1'b0;
            else
                sticky_next = cur;
        end
    endfunction

    // Destuffer drops stuffing zeros before they reach the assembler
    link_zero_destuffer u_destuff (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(control_r[`FLD_DESTUFF_EN]),
        .bit_valid_i(rx_bit_valid_i),
        .bit_data_i(rx_bit_data_i),
        .keep_valid_o(keep_valid),
        .keep_data_o(keep_data)
    );

    // New bit enters at the top so the first bit ends up in bit 0
    assign assembled = {keep_data, shift_r[7:1]};
    assign byte_ev = keep_valid && (count_r == (`BITS_PER_BYTE - 4'h1));
    assign match_ev = byte_ev &&
        (is_match(assembled, match_one_r) || is_match(assembled, match_two_r));

    // Byte assembler; runs regardless of any other receive controller
    // A zero dropped by the destuffer leaves both the byte and the count alone
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            shift_r <= `RST_BYTE;
            count_r <= 4'h0;
            link_byte_r <= `RST_BYTE;
            byte_done_o <= 1'b0;
        end
        else
        begin
            byte_done_o <= byte_ev;
            if (keep_valid)
            begin
                shift_r <= assembled;
                if (byte_ev)
                begin
                    link_byte_r <= assembled;
                    count_r <= 4'h0;
                end
                else
                    count_r <= count_r + 4'h1;
            end
        end
    end

    // Next answer state: one wait state, then one answering cycle
    always @*
    begin
        ack_nxt = ack_r;
        case (ack_r)
            ACK_IDLE:
                if (avs_read_i || avs_write_i)
                    ack_nxt = ACK_ANSWER;
            ACK_ANSWER:
                ack_nxt = ACK_IDLE;
            default:
                ack_nxt = ACK_IDLE;
        endcase
    end

    // Waitrequest drops in the answering cycle; writes land only at its closing edge,
    // the one edge at which the master sees waitrequest low
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (ack_r == ACK_IDLE);
    assign reg_sel = decode_index(avs_address_i);
    assign wr_lane0 = avs_write_i && (ack_r == ACK_ANSWER) && avs_byteenable_i[0];
    assign wr_byte = avs_writedata_i[7:0];
    assign clr_full = wr_lane0 && reg_sel[SEL_STATUS] && wr_byte[`FLD_FULL];
    assign clr_match = wr_lane0 && reg_sel[SEL_STATUS] && wr_byte[`FLD_MATCH];

    // Handshake and register writes
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ack_r <= ACK_IDLE;
            match_one_r <= `RST_MATCH;
            match_two_r <= `RST_MATCH;
            mask_r <= `RST_MASK;
            control_r <= `RST_CONTROL;
        end
        else
        begin
            ack_r <= ack_nxt;
            // Only the implemented flag and control bits are kept
            if (wr_lane0)
            begin
                if (reg_sel[SEL_MATCH_ONE])
                    match_one_r <= wr_byte;
                else if (reg_sel[SEL_MATCH_TWO])
                    match_two_r <= wr_byte;
                else if (reg_sel[SEL_MASK])
                    mask_r <= wr_byte & 8'h14;
                else if (reg_sel[SEL_CONTROL])
                    control_r <= wr_byte & 8'h03;
            end
        end
    end

    // Next status; a new event wins over a same-cycle clear
    always @*
    begin
        status_nxt = status_r;
        status_nxt[`FLD_FULL] = sticky_next(status_r[`FLD_FULL], byte_ev, clr_full);
        status_nxt[`FLD_MATCH] = sticky_next(status_r[`FLD_MATCH], match_ev, clr_match);
    end

    // Sticky status register
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            status_r <= 8'h00;
        else
        begin
            status_r <= status_nxt;
        end
    end

    // Read data latched at the wait-state edge, so it stands at the answering edge
    // A read racing a completing byte returns the byte before it; unmapped reads give zero
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            avs_readdata_o <= 32'h0;
        else if (avs_read_i && (ack_r == ACK_IDLE))
        begin
            if (reg_sel[SEL_BYTE])
                avs_readdata_o <= {24'h0, link_byte_r};
            else if (reg_sel[SEL_MATCH_ONE])
                avs_readdata_o <= {24'h0, match_one_r};
            else if (reg_sel[SEL_MATCH_TWO])
                avs_readdata_o <= {24'h0, match_two_r};
            else if (reg_sel[SEL_STATUS])
                avs_readdata_o <= {24'h0, status_r};
            else if (reg_sel[SEL_MASK])
                avs_readdata_o <= {24'h0, mask_r};
            else if (reg_sel[SEL_CONTROL])
                avs_readdata_o <= {24'h0, control_r};
            else
                avs_readdata_o <= 32'h0;
        end
    end

    // Exactly one transmit source at a time, never a mix
    // Registered, so a select change only takes effect on a clock edge
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            tx_link_bit_o <= 1'b0;
        else if (control_r[`FLD_TX_SRC_HDLC])
            tx_link_bit_o <= tx_hdlc_bit_i;
        else
            tx_link_bit_o <= tx_legacy_bit_i;
    end

    // Level interrupt, low while any unmasked flag stands
    // Built from registers only, so it cannot glitch between clock edges
    assign irq_n_o = !(|(status_r & mask_r));

endmodule
`default_nettype wire

// ===== tb/link_bit_source.sv
// Receive framer model: link bits as one-cycle strobes, bit 0 first.
// Assumes the bench calls send_bits from its main sequence.
`timescale 1ns/1ns
`default_nettype none
module link_bit_source #(
    parameter int GAP = 3
) (
    // Clock
    input wire logic clk_sys_i,
    // Serial link bits
    output var logic bit_valid_o = 1'b0,
    output var logic bit_data_o = 1'b0
);
    // Data flips between strobes so a stale level never passes for a bit
    task automatic send_bits(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys_i);
            bit_valid_o <= 1'b1;
            bit_data_o <= bits[i];
            @(posedge clk_sys_i);
            bit_valid_o <= 1'b0;
            bit_data_o <= ~bits[i];
            repeat (GAP) @(posedge clk_sys_i);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/link_capture_asserts.sv
// Checker for bus, byte and interrupt timing of the link capture.
// Assumes it is bound to link_capture and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module link_capture_asserts (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Register bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Link, transmit select, interrupt
    input wire logic rx_bit_valid_i,
    input wire logic tx_legacy_bit_i,
    input wire logic tx_hdlc_bit_i,
    input wire logic tx_link_bit_o,
    input wire logic byte_done_o,
    input wire logic irq_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [7:0] bits_r;
    // Strobes since last byte; destuffing can only raise the count
    always @(posedge clk_sys_i)
        if (sys_rst_i)
            bits_r <= 8'h00;
        else if (byte_done_o)
            bits_r <= {7'h00, rx_bit_valid_i};
        else
            bits_r <= bits_r + {7'h00, rx_bit_valid_i};
    AST_WAIT_FIRST: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state on new request");
    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest not low after one cycle");
    AST_RD_UPPER: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:8] == 24'h000000) else $error("read data upper bits set");
    AST_DONE_CAUSE: assert property (byte_done_o |-> $past(rx_bit_valid_i))
        else $error("byte done without a bit strobe");
    AST_DONE_COUNT: assert property (byte_done_o |-> bits_r >= 8'h08)
        else $error("byte done before eight bits");
    AST_DONE_PULSE: assert property (byte_done_o |=> !byte_done_o)
        else $error("byte done longer than one cycle");
    AST_IRQ_FALL: assert property ($fell(irq_n_o) |-> byte_done_o || $past(avs_write_i))
        else $error("interrupt without an event");
    AST_IRQ_HOLD: assert property ($rose(irq_n_o) && !$past(sys_rst_i) |-> $past(avs_write_i))
        else $error("interrupt released without a write");
    AST_TX_SRC: assert property (!$past(sys_rst_i) |->
        tx_link_bit_o == $past(tx_legacy_bit_i) || tx_link_bit_o == $past(tx_hdlc_bit_i))
        else $error("transmit bit from no source");
endmodule
bind link_capture link_capture_asserts i_chk (.clk_sys_i, .sys_rst_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .rx_bit_valid_i, .tx_legacy_bit_i,
    .tx_hdlc_bit_i, .tx_link_bit_o, .byte_done_o, .irq_n_o);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the link capture over its Avalon-MM slave.
// Assumes link_capture, its destuffer and the framer model are compiled.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic tx_legacy_bit_i = 1'b1, tx_hdlc_bit_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h00000000, rd;
    logic [3:0] avs_byteenable_i = 4'hf;
    wire logic [31:0] avs_readdata_o;
    wire logic avs_waitrequest_o, rx_bit_valid_i, rx_bit_data_i, tx_link_bit_o;
    wire logic byte_done_o, irq_n_o;
    int mismatches = 0, cmp_count = 0;
    int bytes_seen = 0;
    logic [7:0] idx [7] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h30};
    logic [7:0] byt [3] = '{8'h96, 8'ha5, 8'h3c};
    logic [7:0] msk [3] = '{8'h10, 8'h04, 8'h00};
    logic [7:0] sts [3] = '{8'h10, 8'h14, 8'h14};
    link_capture i_dut (.clk_sys_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .rx_bit_valid_i, .rx_bit_data_i, .tx_legacy_bit_i, .tx_hdlc_bit_i, .tx_link_bit_o,
        .byte_done_o, .irq_n_o);
    link_bit_source #(.GAP(2)) i_src (.clk_sys_i, .bit_valid_o(rx_bit_valid_i),
        .bit_data_o(rx_bit_data_i));
    // 25 MHz system clock
    initial
        forever #20 clk_sys_i = ~clk_sys_i;
    // Count byte strobes on the observer output
    always @(posedge clk_sys_i)
        if (byte_done_o === 1'b1)
            bytes_seen <= bytes_seen + 1;
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        av(1'b0, a, 8'h00);
        chk(name, rd, {24'h000000, exp});
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        test_done;
    end
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // Reset values, unmapped index reads zero
        for (int i = 0; i < 7; i++)
            rchk("reset", idx[i], 8'h00);
        chk("irq_n", irq_n_o, 1);
        // Match registers read-write, link byte read-only
        av(1'b1, 8'h29, 8'ha5);
        av(1'b1, 8'h2a, 8'h3c);
        av(1'b1, 8'h28, 8'hff);
        rchk("match_one", 8'h29, 8'ha5);
        rchk("match_two", 8'h2a, 8'h3c);
        // Write with lane 0 disabled is answered but ignored
        avs_byteenable_i <= 4'he;
        av(1'b1, 8'h29, 8'h00);
        avs_byteenable_i <= 4'hf;
        rchk("lane_off", 8'h29, 8'ha5);
        rchk("link_ro", 8'h28, 8'h00);
        // Plain byte, match on each register; flags, mask and clear
        for (int i = 0; i < 3; i++)
        begin
            av(1'b1, 8'h2c, msk[i]);
            i_src.send_bits({8'h00, byt[i]}, 8);
            rchk("link_byte", 8'h28, byt[i]);
            rchk("status", 8'h2b, sts[i]);
            chk("irq_n", irq_n_o, i / 2);
            av(1'b1, 8'h2b, 8'h14);
            @(posedge clk_sys_i);
            chk("irq_n_clr", irq_n_o, 1);
        end
        // Unread byte overwritten; five ones then zero kept while off
        i_src.send_bits(16'h011f, 16);
        rchk("overwrite", 8'h28, 8'h01);
        // Destuffer on: drop zero after five ones, keep it after six
        av(1'b1, 8'h2d, 8'h01);
        i_src.send_bits(16'h019f, 9);
        rchk("destuff", 8'h28, 8'hdf);
        i_src.send_bits(16'h00bf, 8);
        rchk("six_ones", 8'h28, 8'hbf);
        // Transmit source follows the select bit
        repeat (2) @(posedge clk_sys_i);
        chk("tx_legacy", tx_link_bit_o, 1);
        av(1'b1, 8'h2d, 8'h03);
        repeat (2) @(posedge clk_sys_i);
        chk("tx_hdlc", tx_link_bit_o, 0);
        tx_hdlc_bit_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk("tx_hdlc_hi", tx_link_bit_o, 1);
        chk("byte_count", bytes_seen, 7);
        test_done;
    end
endmodule
`default_nettype wire
